// File: design/qspif_frame_top.sv
// instruction frame sequencer with apb registers and keyed scrambling
`timescale 1ns/1ps
module qspif_frame_top import qspif_pkg::*; #(
    parameter int SCK_HALF = SCK_HALF_CYC,
    // arbitrary per-part value
    parameter logic [31:0] CHIP_RANDOM = 32'h5A3C_96E1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output qspif_link_t link,
    input wire logic [3:0] flash_io
);
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] addr_q;
    logic [31:0] icode_q;
    qspif_frame_t frame_q;
    qspif_sctrl_t sctrl_q;
    logic [31:0] skey_q;
    logic [31:0] txd_q;
    logic [31:0] rxd_q;
    logic done_q;
    logic err_q;
    logic crm_q;
    qspif_state_t st_q;
    qspif_state_t nst;
    logic [5:0] cyc_q;
    logic [1:0] lg_q;
    logic [31:0] sh_q;
    logic [31:0] rx_q;
    logic [15:0] div_q;
    qspif_link_t link_q;
    logic [3:0] io_s;
    logic [31:0] tx_scr;
    logic [31:0] rx_scr;
    logic [31:0] ld_word;
    logic [5:0] ld_cyc;
    logic [1:0] ld_lg;
    logic [5:0] opt_bits;

    logic acc;
    logic wr_en;
    logic busy;
    logic is_read;
    logic ddr;
    logic skip_instr;
    logic start_req;
    logic start_ok;
    logic tick;
    logic rise;
    logic fall;
    logic end_tick;
    logic [3:0] rx_bits;

    function automatic logic is_mapped(input logic [7:0] a);
        return a inside {OFS_ADDR, OFS_ICODE, OFS_FRAME, OFS_SCTRL,
                         OFS_SKEY, OFS_TXD, OFS_RXD, OFS_CMD};
    endfunction

    // next enabled phase after s, in fixed frame order
    function automatic qspif_state_t next_ph(input qspif_state_t s,
                                             input qspif_frame_t f,
                                             input logic skip);
        qspif_state_t n;
        n = ST_END;
        if (s == ST_IDLE && f.instr_phase_on && !skip) begin
            n = ST_INSTR;
        end else if (s inside {ST_IDLE, ST_INSTR} && f.addr_phase_on) begin
            n = ST_ADDR;
        end else if (s inside {ST_IDLE, ST_INSTR, ST_ADDR} && f.option_phase_on) begin
            n = ST_OPT;
        end else if (s inside {ST_IDLE, ST_INSTR, ST_ADDR, ST_OPT}
                     && f.dummy_cycle_count != 5'h00) begin
            n = ST_DUMMY;
        end else if (s != ST_DATA && s != ST_END && f.data_phase_on) begin
            n = ST_DATA;
        end
        return n;
    endfunction

    // log2 of lanes used by a phase for a width code
    function automatic logic [1:0] lane_lg(input logic [2:0] w, input qspif_state_t s);
        logic is_i;
        logic is_d;
        logic [1:0] r;
        is_i = (s == ST_INSTR);
        is_d = (s == ST_DATA);
        case (w)
            3'h0: r = 2'h0;
            3'h1: r = is_d ? 2'h1 : 2'h0;
            3'h2: r = is_d ? 2'h2 : 2'h0;
            3'h3: r = is_i ? 2'h0 : 2'h1;
            3'h4: r = is_i ? 2'h0 : 2'h2;
            3'h5: r = 2'h1;
            3'h6: r = 2'h2;
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    // serial clock cycles for a bit count; partial lane groups round up
    function automatic logic [5:0] cyc_of(input logic [5:0] bits, input logic [1:0] lg,
                                          input logic dbl);
        logic [6:0] t;
        t = 7'(bits) + ((7'h01 << lg) - 7'h01);
        return 6'(t >> ({1'b0, lg} + 3'(dbl)));
    endfunction

    assign acc = psel & penable;
    assign wr_en = acc & pwrite & pready_q;
    assign busy = (st_q != ST_IDLE);
    assign is_read = ~frame_q.transfer_kind[1];
    assign ddr = frame_q.double_rate_on & is_read;
    assign skip_instr = crm_q & frame_q.continuous_read_on & is_read;
    assign start_req = wr_en & (paddr == OFS_CMD) & pwdata[CMD_START_BIT] & ~busy;
    assign start_ok = start_req & (frame_q.lane_width != WIDTH_RSVD);
    assign tick = busy & (div_q == 16'h0000);
    assign rise = tick & ~link_q.sck & (st_q != ST_END);
    assign fall = tick & link_q.sck;
    assign end_tick = tick & (st_q == ST_END);
    assign opt_bits = 6'h01 << frame_q.option_size_sel;
    assign nst = next_ph(st_q, frame_q, skip_instr);

    qspif_sync #(
        .W(4)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(flash_io),
        .sync_out(io_s)
    );

    qspif_scrambler u_tx_scr (
        .user_key(skey_q),
        .chip_random(CHIP_RANDOM),
        .random_mix_off(sctrl_q.random_mix_off),
        .addr(addr_q),
        .data_in(txd_q),
        .data_out(tx_scr)
    );

    qspif_scrambler u_rx_scr (
        .user_key(skey_q),
        .chip_random(CHIP_RANDOM),
        .random_mix_off(sctrl_q.random_mix_off),
        .addr(addr_q),
        .data_in(rx_q),
        .data_out(rx_scr)
    );

    // word, length and lane count for the phase about to start
    always_comb begin
        ld_word = 32'h0000_0000;
        ld_cyc = 6'h01;
        ld_lg = lane_lg(frame_q.lane_width, nst);
        unique case (nst)
            ST_INSTR: begin
                ld_word = {icode_q[7:0], 24'h00_0000};
                ld_cyc = cyc_of(INSTR_BITS, ld_lg, 1'b0);
            end
            ST_ADDR: begin
                ld_word = frame_q.addr_size_sel ? addr_q : {addr_q[23:0], 8'h00};
                ld_cyc = cyc_of(frame_q.addr_size_sel ? ADDR32_BITS : ADDR24_BITS,
                                ld_lg, 1'b0);
            end
            ST_OPT: begin
                ld_word = {icode_q[23:16] << (4'h8 - 4'(opt_bits)), 24'h00_0000};
                ld_cyc = cyc_of(opt_bits, ld_lg, 1'b0);
            end
            ST_DUMMY: begin
                ld_cyc = 6'(frame_q.dummy_cycle_count);
            end
            ST_DATA: begin
                // memory write scrambles, plain write never does
                ld_word = (frame_q.transfer_kind == MEM_WRITE_KIND && sctrl_q.scramble_on)
                          ? tx_scr : txd_q;
                ld_cyc = cyc_of(DATA_BITS, ld_lg, ddr);
            end
            ST_IDLE, ST_END: begin
                ld_cyc = 6'h01;
            end
        endcase
    end

    // apb answer: one wait state, so every output is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~is_mapped(paddr);
            if (acc && !pready_q) begin
                prdata_q <= 32'h0000_0000;
                if (!pwrite) begin
                    unique case (paddr)
                        OFS_ADDR: prdata_q <= addr_q;
                        OFS_ICODE: prdata_q <= icode_q;
                        OFS_FRAME: prdata_q <= frame_q;
                        OFS_SCTRL: prdata_q <= sctrl_q;
                        OFS_TXD: prdata_q <= txd_q;
                        OFS_RXD: prdata_q <= rxd_q;
                        OFS_CMD: prdata_q <= {29'h0000_0000, err_q, done_q, busy};
                        default: prdata_q <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // configuration writes are ignored while a frame runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= ADDR_RST;
            icode_q <= ICODE_RST;
            frame_q <= FRAME_RST;
            sctrl_q <= SCTRL_RST;
            skey_q <= SKEY_RST;
            txd_q <= 32'h0000_0000;
        end else if (wr_en && !busy) begin
            unique case (paddr)
                OFS_ADDR: addr_q <= pwdata;
                OFS_ICODE: icode_q <= pwdata & ICODE_WMASK;
                OFS_FRAME: frame_q <= pwdata & FRAME_WMASK;
                OFS_SCTRL: sctrl_q <= pwdata & SCTRL_WMASK;
                OFS_SKEY: skey_q <= pwdata;
                OFS_TXD: txd_q <= pwdata;
                default: ;
            endcase
        end
    end

    // status flags: a hardware set wins over a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            done_q <= end_tick
                      | (done_q & ~(wr_en && paddr == OFS_CMD && pwdata[CMD_DONE_BIT]));
            err_q <= (start_req & ~start_ok)
                     | (err_q & ~(wr_en && paddr == OFS_CMD && pwdata[CMD_ERR_BIT]));
        end
    end

    // half-period divider for the serial clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 16'h0000;
        end else if (!busy || div_q == 16'h0000) begin
            div_q <= 16'(SCK_HALF - 1);
        end else begin
            div_q <= div_q - 16'h0001;
        end
    end

    // phase sequencer; bits move on the falling serial edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            cyc_q <= 6'h00;
            lg_q <= 2'h0;
            sh_q <= 32'h0000_0000;
        end else if (start_ok || (fall && cyc_q == 6'h01)) begin
            st_q <= nst;
            cyc_q <= ld_cyc;
            lg_q <= ld_lg;
            sh_q <= ld_word;
        end else if (fall) begin
            cyc_q <= cyc_q - 6'h01;
            sh_q <= sh_q << (3'h1 << lg_q);
        end else if (end_tick) begin
            st_q <= ST_IDLE;
        end
    end

    always_comb begin
        unique case (lg_q)
            2'h0: rx_bits = {3'h0, io_s[1]};
            2'h1: rx_bits = {2'h0, io_s[1:0]};
            default: rx_bits = io_s;
        endcase
    end

    // read sampling on the rising edge, and on the falling edge too in double rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_q <= 32'h0000_0000;
        end else if (start_ok) begin
            rx_q <= 32'h0000_0000;
        end else if (st_q == ST_DATA && is_read && (rise || (fall && ddr))) begin
            rx_q <= (rx_q << (3'h1 << lg_q)) | 32'(rx_bits);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_q <= 32'h0000_0000;
        end else if (end_tick && frame_q.data_phase_on && is_read) begin
            // only a memory read unscrambles
            rxd_q <= (frame_q.transfer_kind == MEM_READ_KIND && sctrl_q.scramble_on)
                     ? rx_scr : rx_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crm_q <= 1'b0;
        end else if (!frame_q.continuous_read_on) begin
            crm_q <= 1'b0;
        end else if (end_tick) begin
            crm_q <= is_read;
        end
    end

    // pins: driven one pclk after the shift, well ahead of the rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_q <= '{sck: 1'b0, cs_n: 1'b1, io_out: 4'h0, io_oe_n: 4'hF};
        end else begin
            if (start_ok) begin
                link_q.cs_n <= 1'b0;
            end else if (end_tick) begin
                link_q.cs_n <= 1'b1;
            end
            if (tick && st_q != ST_END) begin
                link_q.sck <= ~link_q.sck;
            end
            unique case (lg_q)
                2'h0: link_q.io_out <= {3'h0, sh_q[31]};
                2'h1: link_q.io_out <= {2'h0, sh_q[31:30]};
                default: link_q.io_out <= sh_q[31:28];
            endcase
            if (st_q inside {ST_INSTR, ST_ADDR, ST_OPT}
                || (st_q == ST_DATA && !is_read)) begin
                link_q.io_oe_n <= (lg_q == 2'h0) ? 4'hE : (lg_q == 2'h1) ? 4'hC : 4'h0;
            end else begin
                link_q.io_oe_n <= 4'hF;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign link = link_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_dummy_len_load: assert property (
        $changed(st_q) && st_q == ST_DUMMY |-> cyc_q == 6'(frame_q.dummy_cycle_count))
        else $error("dummy phase length wrong");

    a_write_no_fall_sample: assert property (
        fall && st_q == ST_DATA && !is_read |=> $stable(rx_q))
        else $error("write frame sampled data");

    a_crm_skips_instr: assert property (
        start_ok && skip_instr |=> st_q != ST_INSTR)
        else $error("continuous read sent instruction");

    a_plain_read_raw: assert property (
        end_tick && frame_q.data_phase_on && frame_q.transfer_kind == PLAIN_READ_KIND
        |=> rxd_q == $past(rx_q))
        else $error("plain read was altered");

    a_mem_read_unscr: assert property (
        end_tick && frame_q.data_phase_on && frame_q.transfer_kind == MEM_READ_KIND
        && sctrl_q.scramble_on |=> rxd_q == $past(rx_scr))
        else $error("memory read not unscrambled");

    a_plain_write_raw: assert property (
        $changed(st_q) && st_q == ST_DATA && frame_q.transfer_kind == PLAIN_WRITE_KIND
        |-> sh_q == txd_q)
        else $error("plain write was scrambled");

    a_mem_write_scr: assert property (
        $changed(st_q) && st_q == ST_DATA && frame_q.transfer_kind == MEM_WRITE_KIND
        && sctrl_q.scramble_on |-> sh_q == tx_scr)
        else $error("memory write not scrambled");

    a_addr_len_cyc: assert property (
        $changed(st_q) && st_q == ST_ADDR
        |-> cyc_q == ((frame_q.addr_size_sel ? 6'h20 : 6'h18) >> lg_q))
        else $error("address length wrong");

    a_phase_enabled: assert property (
        (st_q == ST_INSTR |-> frame_q.instr_phase_on)
        and (st_q == ST_ADDR |-> frame_q.addr_phase_on)
        and (st_q == ST_OPT |-> frame_q.option_phase_on)
        and (st_q == ST_DATA |-> frame_q.data_phase_on))
        else $error("disabled phase emitted");

    a_data_last_phase: assert property (
        st_q == ST_DATA ##1 st_q != ST_DATA |-> st_q == ST_END)
        else $error("phase after data");

    a_single_instr_lane: assert property (
        st_q == ST_INSTR && frame_q.lane_width < 3'h5 |=> link_q.io_oe_n[3:1] == 3'h7)
        else $error("instruction on extra lanes");

    a_key_reads_zero: assert property (
        acc && !pwrite && !pready_q && paddr == OFS_SKEY |=> prdata_q == 32'h0000_0000)
        else $error("user key readable");
endmodule

// File: design/qspif_pkg.sv
// shared constants, register layouts and types of the instruction frame block
package qspif_pkg;
    localparam logic [7:0] OFS_ADDR = 8'h30;
    localparam logic [7:0] OFS_ICODE = 8'h34;
    localparam logic [7:0] OFS_FRAME = 8'h38;
    localparam logic [7:0] OFS_SCTRL = 8'h40;
    localparam logic [7:0] OFS_SKEY = 8'h44;
    localparam logic [7:0] OFS_TXD = 8'h48;
    localparam logic [7:0] OFS_RXD = 8'h4C;
    localparam logic [7:0] OFS_CMD = 8'h50;

    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] ICODE_RST = 32'h0000_0000;
    localparam logic [31:0] FRAME_RST = 32'h0000_0000;
    localparam logic [31:0] SCTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SKEY_RST = 32'h0000_0000;
    localparam logic [31:0] FRAME_WMASK = 32'h001F_F7F7;
    localparam logic [31:0] SCTRL_WMASK = 32'h0000_0003;
    localparam logic [31:0] ICODE_WMASK = 32'h00FF_00FF;

    localparam int CMD_START_BIT = 0;
    localparam int CMD_DONE_BIT = 1;
    localparam int CMD_ERR_BIT = 2;

    localparam logic [1:0] PLAIN_READ_KIND = 2'h0;
    localparam logic [1:0] MEM_READ_KIND = 2'h1;
    localparam logic [1:0] PLAIN_WRITE_KIND = 2'h2;
    localparam logic [1:0] MEM_WRITE_KIND = 2'h3;
    localparam logic [2:0] WIDTH_RSVD = 3'h7;

    localparam logic [5:0] INSTR_BITS = 6'h08;
    localparam logic [5:0] ADDR24_BITS = 6'h18;
    localparam logic [5:0] ADDR32_BITS = 6'h20;
    localparam logic [5:0] DATA_BITS = 6'h20;

    // serial clock period and system clock rate
    localparam int SCK_PERIOD_NS = 320;
    localparam int PCLK_MHZ = 25;
    localparam int SCK_HALF_CYC = SCK_PERIOD_NS * PCLK_MHZ / 2000;

    typedef struct packed {
        logic [10:0] rsvd_hi;
        logic [4:0] dummy_cycle_count;
        logic double_rate_on;
        logic continuous_read_on;
        logic [1:0] transfer_kind;
        logic rsvd_11;
        logic addr_size_sel;
        logic [1:0] option_size_sel;
        logic data_phase_on;
        logic option_phase_on;
        logic addr_phase_on;
        logic instr_phase_on;
        logic rsvd_3;
        logic [2:0] lane_width;
    } qspif_frame_t;

    typedef struct packed {
        logic [29:0] rsvd;
        logic random_mix_off;
        logic scramble_on;
    } qspif_sctrl_t;

    typedef struct packed {
        logic sck;
        logic cs_n;
        logic [3:0] io_out;
        logic [3:0] io_oe_n;
    } qspif_link_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_INSTR, ST_ADDR, ST_OPT, ST_DUMMY, ST_DATA, ST_END
    } qspif_state_t;
endpackage

// File: design/qspif_sync.sv
// two-flop synchroniser for the flash data pins
`timescale 1ns/1ps
module qspif_sync #(
    parameter int W = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// File: design/qspif_scrambler.sv
// keyed xor scrambler; the same operation scrambles and unscrambles
`timescale 1ns/1ps
module qspif_scrambler import qspif_pkg::*; (
    input wire logic [31:0] user_key,
    input wire logic [31:0] chip_random,
    input wire logic random_mix_off,
    input wire logic [31:0] addr,
    input wire logic [31:0] data_in,
    output logic [31:0] data_out
);
    logic [31:0] key_mix;

    // without the chip value a key alone reproduces the stream on any part
    assign key_mix = random_mix_off ? user_key : (user_key ^ chip_random);
    assign data_out = data_in ^ key_mix ^ {addr[15:0], addr[31:16]};
endmodule

// File: tb/qspif_flash_model.sv
// behavioural serial flash: counts clock rises, captures written bits, serves a read word
`timescale 1ns/1ps
module qspif_flash_model import qspif_pkg::*; (
    input wire logic pclk,
    input wire qspif_link_t link,
    input wire logic [2:0] lanes,
    input wire logic [6:0] pre,
    input wire logic ddr,
    input wire logic [31:0] word,
    output logic [3:0] flash_io,
    output logic [7:0] rises,
    output logic [31:0] cap
);
    logic sck_q = 1'b0;
    logic cs_q = 1'b1;
    logic [6:0] i;
    logic [3:0] lmask;
    assign lmask = (lanes == 3'd4) ? 4'hF : (lanes == 3'd2) ? 4'h3 : 4'h1;
    function automatic logic [3:0] slice(input logic [6:0] n);
        logic [31:0] s;
        s = (word << (n * lanes)) >> (32 - lanes);
        return (lanes == 3'd1) ? {2'b00, s[0], 1'b0} : s[3:0];
    endfunction
    initial begin
        flash_io = 4'h5;
        rises = 8'd0;
        cap = 32'h0000_0000;
    end
    always @(posedge pclk) begin
        sck_q <= link.sck;
        cs_q <= link.cs_n;
        i = 7'(rises) - pre;
        if (link.cs_n) begin
            // deselected pins never keep a stale level
            flash_io <= ~flash_io;
        end else if (cs_q) begin
            rises <= 8'd0;
            flash_io <= (pre == 7'd0) ? slice(7'd0) : ~flash_io;
        end else if (link.sck && !sck_q) begin
            rises <= rises + 8'd1;
            cap <= (cap << lanes) | {28'h000_0000, link.io_out & lmask};
            if (ddr && rises >= 8'(pre)) flash_io <= slice(2 * i + 1);
        end else if (!link.sck && sck_q && rises >= 8'(pre)) begin
            flash_io <= slice(ddr ? 2 * i : i);
        end else if (rises < 8'(pre)) begin
            flash_io <= ~flash_io;
        end
    end
endmodule

// File: tb/testbench.sv
// self-checking bench: apb register traffic and frame shapes against a flash model
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench import qspif_pkg::*;;
    localparam logic [31:0] CR = 32'h1234_ABCD; // arbitrary per-part value
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, r, a, v, key, txd, word;
    logic [31:0] seed = 32'hf405_6815;
    logic pready, pslverr, cs_q = 1'b1, ddr = 1'b0;
    qspif_link_t link;
    logic [3:0] fm_io, pins;
    logic [2:0] lanes = 3'd1;
    logic [6:0] pre = 7'd0;
    logic [1:0] osz;
    logic [7:0] rises;
    logic [31:0] cap;
    logic [32:0] exp_rd[$], re;
    logic [40:0] exp_fr[$], fe;
    int n_fail = 0, n_compared = 0, n_r, nd;
    int li[7] = '{1, 1, 1, 1, 1, 2, 4};
    int la[7] = '{1, 1, 1, 2, 4, 2, 4};
    int ld[7] = '{1, 2, 4, 2, 4, 2, 4};
    initial forever #20 pclk = ~pclk;
    assign pins = (link.io_oe_n & fm_io) | (~link.io_oe_n & link.io_out);
    qspif_frame_top #(.SCK_HALF(4), .CHIP_RANDOM(CR)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link), .flash_io(pins));
    qspif_flash_model fm (.pclk(pclk), .link(link), .lanes(lanes), .pre(pre), .ddr(ddr),
        .word(word), .flash_io(fm_io), .rises(rises), .cap(cap));
    task automatic wrap_up();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wt(input logic sig, input logic val, input int lim);
        int n;
        n = 0;
        while ((sig ? link.cs_n : pready) !== val) begin
            @(negedge pclk);
            if (++n > lim) begin
                n_fail++;
                $display("[ERR] %0t wait ran out", $time);
                wrap_up();
            end
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(negedge pclk);
        wt(1'b0, 1'b1, 20);
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [32:0] e);
        exp_rd.push_back(e);
        apb(1'b0, ad, 32'h0000_0000);
    endtask
    task automatic frame(input logic [31:0] f, input logic [7:0] nr, input logic chk,
                         input logic [31:0] val);
        exp_fr.push_back({chk, nr, val});
        apb(1'b1, OFS_FRAME, f);
        apb(1'b1, OFS_CMD, 32'h0000_0001);
        wt(1'b1, 1'b0, 9);
        wt(1'b1, 1'b1, 3000);
        rd(OFS_CMD, 33'h0_0000_0002);
        apb(1'b1, OFS_CMD, 32'h0000_0002);
    endtask
    // results are compared here as they appear, against the oldest note
    always @(negedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_rd.size() > 0) begin
            re = exp_rd.pop_front();
            `CHK({pslverr, prdata}, re)
        end
        if (link.cs_n === 1'b1 && cs_q === 1'b0 && exp_fr.size() > 0) begin
            fe = exp_fr.pop_front();
            `CHK(rises, fe[39:32])
            if (fe[40]) `CHK(cap, fe[31:0])
        end
        cs_q <= link.cs_n;
    end
    initial begin
        word = $random(seed);
        key = $random(seed);
        txd = $random(seed);
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_FRAME, 33'h0);
        rd(OFS_SCTRL, 33'h0);
        rd(OFS_SKEY, 33'h0);
        rd(8'h3C, {1'b1, 32'h0000_0000});
        r = $random(seed);
        apb(1'b1, OFS_FRAME, r);
        rd(OFS_FRAME, {1'b0, r & FRAME_WMASK});
        apb(1'b1, OFS_SKEY, key);
        rd(OFS_SKEY, 33'h0);
        apb(1'b1, OFS_TXD, txd);
        for (int w = 0; w < 7; w++) begin
            r = $random(seed);
            osz = r[9:8] | ((la[w] == 4) ? 2'd2 : (la[w] == 2) ? 2'd1 : 2'd0);
            n_r = 8 / li[w] + (r[5] ? (r[10] ? 32 : 24) / la[w] : 0) + int'(r[20:16]);
            n_r += r[6] ? (1 << osz) / la[w] : 0;
            nd = r[7] ? ((r[15] && !r[13]) ? 16 : 32) / ld[w] : 0;
            pre <= 7'(n_r);
            lanes <= 3'(ld[w]);
            ddr <= r[15] & !r[13];
            frame({11'h0, r[20:15], 1'b0, r[13:12], 1'b0, r[10], osz, r[7:5], 1'b1, 1'b0,
                   3'(w)}, 8'(n_r + nd), r[7] & r[13], txd);
            if (r[7] && !r[13]) rd(OFS_RXD, {1'b0, word});
        end
        apb(1'b1, OFS_FRAME, 32'h0000_0017);
        apb(1'b1, OFS_CMD, 32'h0000_0001);
        rd(OFS_CMD, 33'h0_0000_0004);
        apb(1'b1, OFS_CMD, 32'h0000_0004);
        lanes <= 3'd1;
        ddr <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            pre <= (k == 1) ? 7'd0 : 7'd8;
            frame({17'h0, k != 2, 6'h00, 8'h90}, (k == 1) ? 8'd32 : 8'd40, 1'b0, 0);
            rd(OFS_RXD, {1'b0, word});
        end
        a = {8'h00, 24'($random(seed))};
        apb(1'b1, OFS_ADDR, a);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, OFS_SCTRL, (k < 2) ? 32'h0000_0001 : 32'h0000_0003);
            v = (k < 2) ? word : txd;
            if (k[0]) v = v ^ key ^ ((k < 2) ? CR : 32'h0) ^ {a[15:0], a[31:16]};
            pre <= 7'(24 + 8 * k[0]);
            frame({18'h0, 2'(k), 4'h0, 3'b101, k[0], 4'h0}, 8'(56 + 8 * k[0]), k[1],
                  v);
            if (k < 2) rd(OFS_RXD, {1'b0, v});
        end
        wrap_up();
    end
endmodule
